/* File: pic_defines.svh */
`ifndef PIC_DEFINES_SVH
`define PIC_DEFINES_SVH

// Clock rate and conversion of nanoseconds to whole clock cycles.
`define PIC_CLK_MHZ 250
`define PIC_NS_TO_CYC(ns) ((64'(ns) * 64'(`PIC_CLK_MHZ) + 64'd999) / 64'd1000)

// Deglitch and debounce times in nanoseconds.
`define PIC_OV_DEGLITCH_NS 8000
`define PIC_DEB_100US_NS 100000
`define PIC_DEB_1MS_NS 1000000
`define PIC_DEB_10MS_NS 10000000
`define PIC_DEB_100MS_NS 100000000

// Register byte offsets on the APB port.
`define PIC_ADDR_STATUS 8'h00
`define PIC_ADDR_EVENT 8'h04
`define PIC_ADDR_EVENT_MASK 8'h08
`define PIC_ADDR_STAT_MASK 8'h0C
`define PIC_ADDR_PIN_CFG0 8'h10
`define PIC_PIN_CFG_STRIDE 8'h04
`define PIC_ADDR_CTRL 8'h24
`define PIC_ADDR_CFG_SEL 8'h28

// Field positions.
`define PIC_STATUS_IRQ_BIT 14
`define PIC_CTRL_RELOAD_BIT 6

// Reset values.
`define PIC_EVENT_MASK_RST 14'h0000
`define PIC_STAT_MASK_RST 4'h0
`define PIC_CTRL_RST 6'h10

// Settings loaded by the configuration select input.
`define PIC_CONF0_PIN1 9'h180
`define PIC_CONF0_PIN2 9'h160
`define PIC_CONF0_MASK 4'h0
`define PIC_CONF1_PIN1 9'h06D
`define PIC_CONF1_PIN2 9'h140
`define PIC_CONF1_MASK 4'h0
`define PIC_CONF2_PIN1 9'h000
`define PIC_CONF2_PIN2 9'h000
`define PIC_CONF2_MASK 4'hF

`endif

/* File: pic_pkg.sv */
package pic_pkg;

  localparam int PIC_DEB_CW = 25;

  typedef enum logic [3:0] {
    PIC_FN_OFF = 4'h0,
    PIC_FN_EN1 = 4'h1,
    PIC_FN_EN2 = 4'h2,
    PIC_FN_EN12 = 4'h3,
    PIC_FN_VS1 = 4'h4,
    PIC_FN_VS2 = 4'h5,
    PIC_FN_VS12 = 4'h6,
    PIC_FN_RELOAD = 4'h7,
    PIC_FN_PG1 = 4'h8,
    PIC_FN_PG2 = 4'h9,
    PIC_FN_PG12 = 4'hA,
    PIC_FN_SG = 4'hB,
    PIC_FN_IRQ = 4'hC,
    PIC_FN_RSVD = 4'hD,
    PIC_FN_LOW = 4'hE,
    PIC_FN_HIGH = 4'hF
  } pic_pin_func_t;

  typedef enum logic [1:0] {
    PIC_TRIG_RISE = 2'h0,
    PIC_TRIG_FALL = 2'h1,
    PIC_TRIG_BOTH = 2'h2,
    PIC_TRIG_NONE = 2'h3
  } pic_trig_t;

  typedef struct packed {
    pic_pin_func_t mode;
    logic pol;
    pic_trig_t trig;
    logic [1:0] deb;
  } pic_pin_cfg_t;

  typedef struct packed {
    logic cfg_sel_en;
    logic bus_en;
    logic [1:0] vsel;
    logic [1:0] sw_en;
  } pic_ctrl_t;

  typedef struct packed {
    logic ov2, ov1, oc2, oc1, uv2, uv1, pg2, pg1, tc, tw;
  } pic_ana_t;

  typedef struct packed {
    logic [2:0] gpio;
    logic pg2, ov2, uv2, oc2, pg1, ov1, uv1, oc1, sg, tc, tw;
  } pic_ev_t;

endpackage : pic_pkg

/* File: pic_filt_if.sv */
`timescale 1ns/1ps
interface pic_filt_if #(parameter int CW = 25) ();
  logic raw;
  logic [CW-1:0] limit;
  logic level;
  modport owner (output raw, output limit, input level);
  modport filt (input raw, input limit, output level);
endinterface : pic_filt_if

/* File: pic_debounce.sv */
`timescale 1ns/1ps
module pic_debounce #(
  parameter int CW = 25
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  pic_filt_if.filt f
);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic level;
  } pic_deb_state_t;

  pic_deb_state_t st_r;
  pic_deb_state_t st_nxt;
  logic [CW-1:0] cnt_inc;

  if (CW < 2) begin : g_chk
    $error("pic_debounce: counter width too small.");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // The level follows the input only after it has differed for limit cycles.
  always_comb begin
    st_nxt = st_r;
    cnt_inc = CW'(st_r.cnt + 1'b1);
    if (f.raw == st_r.level) begin
      st_nxt.cnt = '0;
    end else if (cnt_inc >= f.limit) begin
      st_nxt.level = f.raw;
      st_nxt.cnt = '0;
    end else begin
      st_nxt.cnt = cnt_inc;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign f.level = st_r.level;

  ////////////////////////////////////////////////////////////////////////////////
  a_level_follows_raw: assert property ( // see RQ5
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    (st_r.level != st_nxt.level) |-> (st_nxt.level == f.raw) && (st_r.cnt >= CW'(f.limit - 1'b1) || f.limit <= 1))
  else $error("Filter level changed without a stable input.");

endmodule : pic_debounce

/* File: pic_irq_gpio_top.sv */
`timescale 1ns/1ps
`include "pic_defines.svh"
// What this block does
// RQ1 - Chip enable low: all off, outputs pulled down.
// RQ2 - Thermal warning and critical set flags, undelayed.
// RQ3 - Either channel power-good event raises system-good event.
// RQ4 - Entering good window raises power-good event immediately.
// RQ5 - Over-voltage event, comparator deglitched 8 us both ways.
// RQ6 - Under-voltage event raised without deglitch delay.
// RQ7 - Over-current event raised without deglitch delay.
// RQ8 - Pin change event per trigger, selectable debounce.
// RQ9 - Status interrupts follow live status, no clearing.
// RQ10 - Event flags sticky until host writes clear.
// RQ11 - Event mask gates interrupt, flag still updates.
// RQ12 - Status masks gate status interrupts only.
// RQ13 - Power-good status true only inside window.
// RQ14 - System good status when either channel good.
// RQ15 - Pin function code C outputs the interrupt.
// RQ16 - Polarity zero: interrupt line high, low on event.
// RQ17 - Serial bus enabled: pins three, four released.
// RQ18 - Serial bus disabled: pins three, four outputs only.
// RQ19 - Input function codes zero to seven.
// RQ20 - Output function codes eight to fifteen, except reserved code D.
// RQ21 - Config select samples pin zero: low, high, floating.
// RQ22 - Chosen config loads pins one and two and the status masks.
// RQ23 - Host waits enable delay before serial traffic.
// RQ24 - Off: buck channels disabled, pull-downs enabled.
// RQ25 - Polarity one inverts the interrupt output.
// RQ26 - Unmasked events and status sources ORed together.
module pic_irq_gpio_top
  import pic_pkg::*;
#(
  parameter logic [PIC_DEB_CW-1:0] DEB_100US_CYC = PIC_DEB_CW'(`PIC_NS_TO_CYC(`PIC_DEB_100US_NS)),
  parameter logic [PIC_DEB_CW-1:0] DEB_1MS_CYC = PIC_DEB_CW'(`PIC_NS_TO_CYC(`PIC_DEB_1MS_NS)),
  parameter logic [PIC_DEB_CW-1:0] DEB_10MS_CYC = PIC_DEB_CW'(`PIC_NS_TO_CYC(`PIC_DEB_10MS_NS)),
  parameter logic [PIC_DEB_CW-1:0] DEB_100MS_CYC = PIC_DEB_CW'(`PIC_NS_TO_CYC(`PIC_DEB_100MS_NS))
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic chip_enable_pin_in,
  input wire logic thermal_warn_in,
  input wire logic thermal_crit_in,
  input wire logic [1:0] ch_power_good_in,
  input wire logic [1:0] ch_overvoltage_in,
  input wire logic [1:0] ch_undervoltage_in,
  input wire logic [1:0] ch_overcurrent_in,
  input wire logic [2:0] pin_in,
  input wire logic pin0_float_in,
  output logic [4:0] pin_out,
  output logic [4:0] pin_oe_n_out,
  output logic [1:0] ch_enable_out,
  output logic [1:0] ch_pulldown_out,
  output logic [1:0] ch_vsel_out,
  output logic [1:0] config_index_out,
  output logic config_load_out
);

  localparam logic [PIC_DEB_CW-1:0] OV_CYC = PIC_DEB_CW'(`PIC_NS_TO_CYC(`PIC_OV_DEGLITCH_NS));
  localparam logic [11:0] OV_RUN_MAX = 12'hFFF;

  typedef struct packed {
    logic ce_meta;
    logic ce_s;
    logic ce_prev;
    pic_ana_t a_meta;
    pic_ana_t a_s;
    pic_ana_t lv_prev;
    logic [2:0] p_meta;
    logic [2:0] p_s;
    logic fl_meta;
    logic fl_s;
    logic [2:0] gp_prev;
    pic_ev_t ev;
    logic [13:0] ev_mask;
    logic [3:0] st_mask;
    pic_pin_cfg_t [4:0] cfg;
    pic_ctrl_t ctrl;
    logic [1:0] cfg_idx;
    logic cfg_load;
    logic [31:0] rdata;
    logic irq;
    logic [1:0] ch_en;
    logic [1:0] ch_vsel;
    logic [4:0] pin_o;
    logic [4:0] pin_oe_n;
    logic [11:0] ov_run;
  } pic_top_state_t;

  pic_top_state_t st_r;
  pic_top_state_t st_nxt;
  logic [4:0] filt_lvl;
  pic_ana_t live;
  pic_ana_t rise;
  pic_ev_t set_ev;
  pic_ev_t clr_ev;
  pic_ev_t stat;
  logic [2:0] gp_lvl;
  logic [2:0] chg;
  logic [2:0] pin_ok;
  logic [1:0] pin_en;
  logic [1:0] pin_vs;
  logic reload;
  logic sys_good;
  logic irq;
  logic acc;
  logic wr;
  logic [1:0] dv;
  logic [1:0] idx;

  if (DEB_100US_CYC == '0 || DEB_1MS_CYC == '0 || DEB_10MS_CYC == '0 || DEB_100MS_CYC == '0) begin : g_chk
    $error("pic_irq_gpio_top: debounce counts must be nonzero.");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Helper functions.
  function automatic logic [PIC_DEB_CW-1:0] deb_limit(input logic [1:0] sel);
    logic [PIC_DEB_CW-1:0] lim;
    unique case (sel)
      2'h0: lim = DEB_100US_CYC;
      2'h1: lim = DEB_1MS_CYC;
      2'h2: lim = DEB_10MS_CYC;
      2'h3: lim = DEB_100MS_CYC;
    endcase
    return lim;
  endfunction : deb_limit

  function automatic logic pin_is(input pic_pin_cfg_t c, input pic_pin_func_t f0, input pic_pin_func_t f1);
    return (c.mode == f0) || (c.mode == f1);
  endfunction : pin_is

  function automatic logic [1:0] pin_drive(input pic_pin_cfg_t c, input logic rq, input logic g1,
                                           input logic g2, input logic sg);
    logic [1:0] r;
    unique case (c.mode)
      PIC_FN_OFF, PIC_FN_EN1, PIC_FN_EN2, PIC_FN_EN12, PIC_FN_VS1, PIC_FN_VS2, PIC_FN_VS12,
      PIC_FN_RELOAD, PIC_FN_RSVD: r = 2'h0; // see RQ19
      PIC_FN_PG1: r = {1'b1, g1}; // see RQ20
      PIC_FN_PG2: r = {1'b1, g2};
      PIC_FN_PG12: r = {1'b1, g1 & g2};
      PIC_FN_SG: r = {1'b1, sg};
      PIC_FN_IRQ: r = {1'b1, ~rq}; // see RQ15
      PIC_FN_LOW: r = 2'h2;
      PIC_FN_HIGH: r = 2'h3;
    endcase
    return r;
  endfunction : pin_drive

  function automatic logic addr_mapped(input logic [7:0] a);
    logic hit;
    hit = (a == `PIC_ADDR_STATUS) || (a == `PIC_ADDR_EVENT) || (a == `PIC_ADDR_EVENT_MASK) ||
          (a == `PIC_ADDR_STAT_MASK) || (a == `PIC_ADDR_CTRL) || (a == `PIC_ADDR_CFG_SEL);
    for (int i = 0; i < 5; i++) begin
      hit = hit || (a == 8'(`PIC_ADDR_PIN_CFG0 + i * `PIC_PIN_CFG_STRIDE));
    end
    return hit;
  endfunction : addr_mapped

  ////////////////////////////////////////////////////////////////////////////////
  // Deglitch filters: two over-voltage comparators, then pins zero to two.
  pic_filt_if #(.CW(PIC_DEB_CW)) fi [5] ();

  for (genvar gi = 0; gi < 5; gi++) begin : g_filt
    pic_debounce #(.CW(PIC_DEB_CW)) u_deb (
      .clk_sys_in(clk_sys_in),
      .reset_n_in(reset_n_in),
      .f(fi[gi])
    );
    if (gi < 2) begin : g_ov
      assign fi[gi].raw = (gi == 0) ? st_r.a_s.ov1 : st_r.a_s.ov2;
      assign fi[gi].limit = OV_CYC; // see RQ5
    end else begin : g_pin
      assign fi[gi].raw = st_r.p_s[gi-2];
      assign fi[gi].limit = deb_limit(st_r.cfg[gi-2].deb); // see RQ8
    end
    assign filt_lvl[gi] = fi[gi].level;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    st_nxt = st_r;
    idx = 2'h0;
    dv = 2'h0;
    pin_en = 2'h0;
    pin_vs = 2'h0;
    reload = 1'b0;
    st_nxt.ce_meta = chip_enable_pin_in;
    st_nxt.ce_s = st_r.ce_meta;
    st_nxt.ce_prev = st_r.ce_s;
    st_nxt.a_meta = {ch_overvoltage_in[1], ch_overvoltage_in[0], ch_overcurrent_in[1], ch_overcurrent_in[0],
                     ch_undervoltage_in[1], ch_undervoltage_in[0], ch_power_good_in[1], ch_power_good_in[0],
                     thermal_crit_in, thermal_warn_in};
    st_nxt.a_s = st_r.a_meta;
    st_nxt.p_meta = pin_in;
    st_nxt.p_s = st_r.p_meta;
    st_nxt.fl_meta = pin0_float_in;
    st_nxt.fl_s = st_r.fl_meta;
    live = st_r.a_s;
    live.ov1 = filt_lvl[0];
    live.ov2 = filt_lvl[1];
    st_nxt.lv_prev = live;
    rise = live & ~st_r.lv_prev;
    st_nxt.ov_run = st_r.a_s.ov1 ? ((st_r.ov_run == OV_RUN_MAX) ? OV_RUN_MAX : 12'(st_r.ov_run + 1'b1)) : 12'h000;
    // Pin inputs, change detection and input functions.
    for (int i = 0; i < 3; i++) begin
      gp_lvl[i] = filt_lvl[i+2] ^ st_r.cfg[i].pol;
      pin_ok[i] = (i != 0) || !st_r.ctrl.cfg_sel_en;
      unique case (st_r.cfg[i].trig)
        PIC_TRIG_RISE: chg[i] = gp_lvl[i] & ~st_r.gp_prev[i]; // see RQ8
        PIC_TRIG_FALL: chg[i] = ~gp_lvl[i] & st_r.gp_prev[i];
        PIC_TRIG_BOTH: chg[i] = gp_lvl[i] ^ st_r.gp_prev[i];
        PIC_TRIG_NONE: chg[i] = 1'b0;
      endcase
      chg[i] = chg[i] & pin_ok[i];
      if (pin_ok[i] && gp_lvl[i]) begin // see RQ19
        pin_en[0] = pin_en[0] | pin_is(st_r.cfg[i], PIC_FN_EN1, PIC_FN_EN12);
        pin_en[1] = pin_en[1] | pin_is(st_r.cfg[i], PIC_FN_EN2, PIC_FN_EN12);
        pin_vs[0] = pin_vs[0] | pin_is(st_r.cfg[i], PIC_FN_VS1, PIC_FN_VS12);
        pin_vs[1] = pin_vs[1] | pin_is(st_r.cfg[i], PIC_FN_VS2, PIC_FN_VS12);
        reload = reload | (pin_is(st_r.cfg[i], PIC_FN_RELOAD, PIC_FN_RELOAD) & ~st_r.gp_prev[i]);
      end
    end
    st_nxt.gp_prev = gp_lvl;
    // Events and live status.
    sys_good = live.pg1 | live.pg2; // see RQ13 RQ14
    set_ev = '0;
    set_ev.tw = rise.tw; // see RQ2
    set_ev.tc = rise.tc;
    set_ev.sg = rise.pg1 | rise.pg2; // see RQ3
    set_ev.pg1 = rise.pg1; // see RQ4
    set_ev.pg2 = rise.pg2;
    set_ev.ov1 = rise.ov1; // see RQ5
    set_ev.ov2 = rise.ov2;
    set_ev.uv1 = rise.uv1; // see RQ6
    set_ev.uv2 = rise.uv2;
    set_ev.oc1 = rise.oc1; // see RQ7
    set_ev.oc2 = rise.oc2;
    set_ev.gpio = chg;
    stat = {gp_lvl, live.pg2, live.ov2, live.uv2, live.oc2, live.pg1, live.ov1, live.uv1, live.oc1, sys_good,
            live.tc, live.tw};
    irq = (|(st_r.ev & ~st_r.ev_mask)) | // see RQ11 RQ26
          (|({live.tw, ~sys_good, ~live.pg2, ~live.pg1} & ~st_r.st_mask)); // see RQ9 RQ12
    st_nxt.irq = irq;
    // APB slave: read data captured in setup, writes take effect in the access cycle.
    acc = psel_in & penable_in;
    wr = acc & pwrite_in & addr_mapped(paddr_in);
    clr_ev = (wr && paddr_in == `PIC_ADDR_EVENT) ? pic_ev_t'(pwdata_in[13:0]) : pic_ev_t'(14'h0000);
    st_nxt.ev = (st_r.ev & ~clr_ev) | set_ev; // see RQ10
    if (psel_in && !penable_in) begin
      st_nxt.rdata = 32'h0000_0000;
      unique case (paddr_in)
        `PIC_ADDR_STATUS: st_nxt.rdata = 32'({irq, stat});
        `PIC_ADDR_EVENT: st_nxt.rdata = 32'(st_r.ev);
        `PIC_ADDR_EVENT_MASK: st_nxt.rdata = 32'(st_r.ev_mask);
        `PIC_ADDR_STAT_MASK: st_nxt.rdata = 32'(st_r.st_mask);
        `PIC_ADDR_CTRL: st_nxt.rdata = 32'(st_r.ctrl);
        `PIC_ADDR_CFG_SEL: st_nxt.rdata = 32'(st_r.cfg_idx);
        default: begin
          for (int i = 0; i < 5; i++) begin
            if (paddr_in == 8'(`PIC_ADDR_PIN_CFG0 + i * `PIC_PIN_CFG_STRIDE)) begin
              st_nxt.rdata = 32'(st_r.cfg[i]);
            end
          end
        end
      endcase
    end
    if (wr) begin
      unique case (paddr_in)
        `PIC_ADDR_EVENT_MASK: st_nxt.ev_mask = pwdata_in[13:0];
        `PIC_ADDR_STAT_MASK: st_nxt.st_mask = pwdata_in[3:0];
        `PIC_ADDR_CTRL: begin
          st_nxt.ctrl = pic_ctrl_t'(pwdata_in[5:0]);
          reload = reload | pwdata_in[`PIC_CTRL_RELOAD_BIT];
        end
        default: begin
          for (int i = 0; i < 5; i++) begin
            if (paddr_in == 8'(`PIC_ADDR_PIN_CFG0 + i * `PIC_PIN_CFG_STRIDE)) begin
              st_nxt.cfg[i] = pic_pin_cfg_t'(pwdata_in[8:0]);
            end
          end
        end
      endcase
    end
    // Configuration select on chip enable or on reload.
    st_nxt.cfg_load = 1'b0;
    if (((st_r.ce_s && !st_r.ce_prev) || reload) && st_r.ctrl.cfg_sel_en) begin
      idx = st_r.fl_s ? 2'h2 : {1'b0, st_r.p_s[0]}; // see RQ21
      st_nxt.cfg_idx = idx;
      st_nxt.cfg_load = 1'b1;
      unique case (idx)
        2'h0: begin // see RQ22
          st_nxt.cfg[1] = pic_pin_cfg_t'(`PIC_CONF0_PIN1);
          st_nxt.cfg[2] = pic_pin_cfg_t'(`PIC_CONF0_PIN2);
          st_nxt.st_mask = `PIC_CONF0_MASK;
        end
        2'h1: begin
          st_nxt.cfg[1] = pic_pin_cfg_t'(`PIC_CONF1_PIN1);
          st_nxt.cfg[2] = pic_pin_cfg_t'(`PIC_CONF1_PIN2);
          st_nxt.st_mask = `PIC_CONF1_MASK;
        end
        default: begin
          st_nxt.cfg[1] = pic_pin_cfg_t'(`PIC_CONF2_PIN1);
          st_nxt.cfg[2] = pic_pin_cfg_t'(`PIC_CONF2_PIN2);
          st_nxt.st_mask = `PIC_CONF2_MASK;
        end
      endcase
    end
    // Buck controls and pin drivers.
    st_nxt.ch_en = {2{st_r.ce_s & ~live.tc}} & (st_r.ctrl.sw_en | pin_en); // see RQ1 RQ24
    st_nxt.ch_vsel = st_r.ctrl.vsel | pin_vs;
    for (int i = 0; i < 5; i++) begin
      dv = pin_drive(st_r.cfg[i], irq, live.pg1, live.pg2, sys_good);
      st_nxt.pin_o[i] = dv[0] ^ st_r.cfg[i].pol; // see RQ16 RQ25
      st_nxt.pin_oe_n[i] = ~(dv[1] & st_r.ce_s & ~((i == 0) & st_r.ctrl.cfg_sel_en) &
                              ~((i >= 3) & st_r.ctrl.bus_en)); // see RQ17 RQ18
    end
    if (!st_r.ce_s) begin
      st_nxt.ev = '0; // see RQ1
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_r <= '0;
      st_r.ev_mask <= `PIC_EVENT_MASK_RST;
      st_r.st_mask <= `PIC_STAT_MASK_RST;
      st_r.ctrl <= pic_ctrl_t'(`PIC_CTRL_RST);
      st_r.pin_oe_n <= 5'h1F;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata_out = st_r.rdata;
  assign pready_out = acc;
  assign pslverr_out = acc & ~addr_mapped(paddr_in);
  assign pin_out = st_r.pin_o;
  assign pin_oe_n_out = st_r.pin_oe_n;
  assign ch_enable_out = st_r.ch_en;
  assign ch_pulldown_out = ~st_r.ch_en; // see RQ24
  assign ch_vsel_out = st_r.ch_vsel;
  assign config_index_out = st_r.cfg_idx;
  assign config_load_out = st_r.cfg_load;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_pg_enter;
    (rise.pg1 || rise.pg2) && st_r.ce_s;
  endsequence

  sequence s_irq_pin1(logic p);
    st_r.cfg[1].mode == PIC_FN_IRQ && st_r.cfg[1].pol == p && st_r.ce_s;
  endsequence

  a_off_all_down: assert property ( // see RQ1
    !st_r.ce_s |=> st_r.ch_en == 2'h0 && ch_pulldown_out == 2'h3 && pin_oe_n_out == 5'h1F && st_r.ev == '0)
  else $error("Outputs not released while chip enable is low.");
  a_thermal_crit_flag: assert property ( // see RQ2
    rise.tc && st_r.ce_s |=> st_r.ev.tc && !st_r.ch_en[0])
  else $error("Thermal critical flag not set at once.");
  a_sysgood_event: assert property ( // see RQ3
    s_pg_enter |=> st_r.ev.sg && (st_r.ev.pg1 || st_r.ev.pg2))
  else $error("Power-good entry did not set both events.");
  a_ov_deglitch: assert property ( // see RQ5
    $rose(filt_lvl[0]) |-> st_r.ov_run >= 12'(OV_CYC))
  else $error("Over-voltage passed the filter too early.");
  a_uv_undelayed: assert property ( // see RQ6
    rise.uv2 && st_r.ce_s |=> st_r.ev.uv2)
  else $error("Under-voltage event late.");
  a_set_beats_clear: assert property ( // see RQ7 RQ10
    set_ev.oc2 && clr_ev.oc2 && st_r.ce_s |=> st_r.ev.oc2)
  else $error("Over-current event lost to a clear.");
  a_flag_sticky: assert property ( // see RQ10
    st_r.ev.oc1 && !clr_ev.oc1 && st_r.ce_s |=> st_r.ev.oc1)
  else $error("Event flag dropped without a clear.");
  a_mask_keeps_flag: assert property ( // see RQ11
    set_ev.uv1 && st_r.ev_mask[4] && st_r.ce_s |=> st_r.ev.uv1)
  else $error("Masked event did not update its flag.");
  a_hot_status_irq: assert property ( // see RQ9
    live.tw && !st_r.st_mask[3] |-> irq ##1 st_r.irq)
  else $error("Thermal warning status not on the interrupt.");
  a_irq_pin_low: assert property ( // see RQ15 RQ16
    s_irq_pin1(1'b0) |=> !pin_oe_n_out[1] && pin_out[1] == !$past(irq))
  else $error("Interrupt pin level wrong with polarity zero.");
  a_irq_pin_high: assert property ( // see RQ25
    s_irq_pin1(1'b1) |=> pin_out[1] == $past(irq))
  else $error("Interrupt pin level wrong with polarity one.");
  a_bus_pins_free: assert property ( // see RQ17
    st_r.ctrl.bus_en |=> pin_oe_n_out[4:3] == 2'h3)
  else $error("Serial bus pins driven while the bus owns them.");
  a_config_select_input_high_pick: assert property ( // see RQ21 RQ22
    reload && st_r.ctrl.cfg_sel_en && !st_r.fl_s && st_r.p_s[0] |=>
      config_load_out && config_index_out == 2'h1 && st_r.cfg[1] == pic_pin_cfg_t'(`PIC_CONF1_PIN1))
  else $error("High select pin did not load the second configuration.");

endmodule : pic_irq_gpio_top

/* File: pic_pin_host.sv */
`timescale 1ns/1ps
module pic_pin_host (
  input wire logic clk_sys_in,
  input wire logic [2:0] host_en_in,
  input wire logic [2:0] host_val_in,
  input wire logic [4:0] pin_out_in,
  input wire logic [4:0] pin_oe_n_in,
  output logic [2:0] level_out
);
  logic toggle_r = 1'b0;
  // A pin that nobody drives shows a level that changes every cycle.
  always_ff @(posedge clk_sys_in) begin
    toggle_r <= ~toggle_r;
  end
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      level_out[i] = !pin_oe_n_in[i] ? pin_out_in[i] : (host_en_in[i] ? host_val_in[i] : toggle_r);
    end
  end
endmodule : pic_pin_host

/* File: testbench.sv */
`timescale 1ns/1ps
`include "pic_defines.svh"
module testbench;
  import pic_pkg::*;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ce = 1'b1, tw = 1'b0, tc = 1'b0, fl = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, sl, cload;
  logic [1:0] pg = 2'h3, ov = 2'h0, uv = 2'h0, oc = 2'h0, chen, chpd, vsel, cidx;
  logic [2:0] lvl, hen = 3'h7, hval = 3'h0;
  logic [4:0] pin, oe_n;
  int errors = 0, comparisons = 0, loads = 0;
  // Each row is function code, expected active-low output enable, expected level.
  logic [5:0] rows [16] = '{6'h02, 6'h06, 6'h0A, 6'h0E, 6'h12, 6'h16, 6'h1A, 6'h1E, 6'h21, 6'h25, 6'h29, 6'h2D,
    6'h31, 6'h36, 6'h38, 6'h3D};

  pic_irq_gpio_top #(.DEB_100US_CYC(25'd4), .DEB_1MS_CYC(25'd8), .DEB_10MS_CYC(25'd16),
    .DEB_100MS_CYC(25'd32)) i_pic_irq_gpio_top (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .paddr_in(paddr), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .chip_enable_pin_in(ce),
    .thermal_warn_in(tw), .thermal_crit_in(tc), .ch_power_good_in(pg), .ch_overvoltage_in(ov),
    .ch_undervoltage_in(uv), .ch_overcurrent_in(oc), .pin_in(lvl), .pin0_float_in(fl), .pin_out(pin),
    .pin_oe_n_out(oe_n), .ch_enable_out(chen), .ch_pulldown_out(chpd), .ch_vsel_out(vsel),
    .config_index_out(cidx), .config_load_out(cload));
  pic_pin_host i_pic_pin_host (.clk_sys_in(clk_sys_in), .host_en_in(hen), .host_val_in(hval),
    .pin_out_in(pin), .pin_oe_n_in(oe_n), .level_out(lvl));

  initial begin
    forever #2 clk_sys_in = ~clk_sys_in;
  end

  // Counts configuration load pulses.
  always @(posedge clk_sys_in) begin
    if (cload === 1'b1) loads++;
  end

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys_in);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    @(posedge clk_sys_in);
    while (pready !== 1'b1) @(posedge clk_sys_in);
    rd = prdata;
    sl = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
  endtask : apb

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic print_verdict;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20000) @(posedge clk_sys_in);
    errors++;
    print_verdict();
  end

  initial begin
    repeat (20) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    repeat (10) @(posedge clk_sys_in);
    apb(`PIC_ADDR_CTRL, 1'b0, 32'h0);
    chk("ctrl_reset", rd, 32'h10);
    apb(`PIC_ADDR_EVENT_MASK, 1'b0, 32'h0);
    chk("mask_reset", rd, 32'h0);
    apb(8'h30, 1'b0, 32'h0);
    chk("unmapped", {rd[31:1], sl}, 32'h1);
    apb(`PIC_ADDR_EVENT_MASK, 1'b1, 32'h3800);
    apb(`PIC_ADDR_EVENT, 1'b1, 32'h3FFF);
    apb(`PIC_ADDR_STATUS, 1'b0, 32'h0);
    chk("status_idle", rd, 32'h444);
    foreach (rows[i]) begin
      apb(`PIC_ADDR_PIN_CFG0 + 8'h04, 1'b1, {23'h0, rows[i][5:2], 5'h0C});
      chk("pin1_oe_n", oe_n[1], rows[i][1]);
      if (rows[i][1] == 1'b0) chk("pin1_val", pin[1], rows[i][0]);
    end
    apb(`PIC_ADDR_PIN_CFG0 + 8'h04, 1'b1, 32'h18C);
    uv[0] <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    chk("irq_low", pin[1], 1'b0);
    uv[0] <= 1'b0;
    apb(`PIC_ADDR_EVENT, 1'b0, 32'h0);
    chk("uv1_sticky", rd, 32'h10);
    apb(`PIC_ADDR_EVENT, 1'b1, 32'h10);
    apb(`PIC_ADDR_EVENT, 1'b0, 32'h0);
    chk("uv1_clear", {rd[30:0], pin[1]}, 32'h1);
    apb(`PIC_ADDR_EVENT_MASK, 1'b1, 32'h3810);
    uv[0] <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    chk("masked_quiet", pin[1], 1'b1);
    uv[0] <= 1'b0;
    apb(`PIC_ADDR_EVENT, 1'b0, 32'h0);
    chk("masked_flag", rd, 32'h10);
    apb(`PIC_ADDR_EVENT, 1'b1, 32'h10);
    apb(`PIC_ADDR_EVENT_MASK, 1'b1, 32'h3800);
    apb(`PIC_ADDR_PIN_CFG0 + 8'h04, 1'b1, 32'h19C);
    chk("pol1_quiet", pin[1], 1'b0);
    oc[1] <= 1'b1;
    tc <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    chk("pol1_irq", pin[1], 1'b1);
    oc[1] <= 1'b0;
    tc <= 1'b0;
    apb(`PIC_ADDR_EVENT, 1'b0, 32'h0);
    chk("oc2_tc_flags", rd, 32'h82);
    apb(`PIC_ADDR_EVENT, 1'b1, 32'h82);
    pg[0] <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    chk("pg1_stat_irq", pin[1], 1'b1);
    apb(`PIC_ADDR_STAT_MASK, 1'b1, 32'h1);
    chk("pg1_masked", pin[1], 1'b0);
    apb(`PIC_ADDR_STATUS, 1'b0, 32'h0);
    chk("pg1_low", rd, 32'h404);
    pg[0] <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    apb(`PIC_ADDR_EVENT, 1'b0, 32'h0);
    chk("pg1_sg_event", rd, 32'h44);
    apb(`PIC_ADDR_EVENT, 1'b1, 32'h44);
    apb(`PIC_ADDR_EVENT_MASK, 1'b1, 32'h3801);
    tw <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    chk("hot_stat_irq", pin[1], 1'b1);
    apb(`PIC_ADDR_STAT_MASK, 1'b1, 32'h9);
    chk("hot_masked", pin[1], 1'b0);
    tw <= 1'b0;
    apb(`PIC_ADDR_EVENT, 1'b0, 32'h0);
    chk("tw_flag", rd, 32'h1);
    ov[0] <= 1'b1;
    repeat (1990) @(posedge clk_sys_in);
    apb(`PIC_ADDR_EVENT, 1'b0, 32'h0);
    chk("ov1_early", rd[5], 1'b0);
    repeat (20) @(posedge clk_sys_in);
    apb(`PIC_ADDR_EVENT, 1'b0, 32'h0);
    chk("ov1_late", rd[5], 1'b1);
    apb(`PIC_ADDR_PIN_CFG0 + 8'h0C, 1'b1, 32'h1E0);
    chk("pin3_bus", oe_n[3], 1'b1);
    apb(`PIC_ADDR_CTRL, 1'b1, 32'h03);
    chk("pin3_drive", {oe_n[3], pin[3], chen}, 4'h7);
    apb(`PIC_ADDR_PIN_CFG0 + 8'h0C, 1'b1, 32'h020);
    chk("pin3_no_input", oe_n[3], 1'b1);
    hval[0] <= 1'b1;
    apb(`PIC_ADDR_CTRL, 1'b1, 32'h2C);
    apb(`PIC_ADDR_CTRL, 1'b1, 32'h6C);
    chk("config_select_input_high", {cidx, vsel}, 4'h7);
    chk("config_select_input_load", loads, 1);
    apb(`PIC_ADDR_PIN_CFG0 + 8'h04, 1'b0, 32'h0);
    chk("config_select_input_pin1", rd, 32'h06D);
    apb(`PIC_ADDR_EVENT, 1'b0, 32'h0);
    chk("pin2_change", rd[13], 1'b1);
    ce <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    chk("chip_off", {chen, chpd, oe_n}, {2'b00, 2'b11, 5'h1F});
    print_verdict();
  end
endmodule : testbench
